// >>> rpsl_bench.sv
// Purpose: self-checking bench of the pin routing block with lock and key sequence
// Assumes: one-way bit is taken while reset is high
// Notes: waits are fixed counts because the bus never stalls
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_params.svh"
module rpsl_bench;
  logic                            core_clk_i;
  logic                            rst_i;
  rpsl_pkg::rpsl_bus_req_t         bus_i;
  logic [15:0]                     rdata_o;
  logic [15:0]                     config_word_two_i;
  wire logic [`RPSL_PINS-1:0]      pin_in_i;
  wire logic [`RPSL_PERIPH_OUTS-1:0] periph_out_i;
  rpsl_pkg::rpsl_periph_in_t       periph_in_o;
  logic [3:0]                      periph_in_valid_o;
  logic [`RPSL_IO_PINS-1:0]        pin_out_o;
  logic [`RPSL_IO_PINS-1:0]        pin_oe_o;
  logic                            remap_lock_o;
  logic                            config_mismatch_reset_o;
  int                              bad_count;
  int                              checks_done;

  rpsl_top dut_u (
    .core_clk_i              (core_clk_i),
    .rst_i                   (rst_i),
    .bus_i                   (bus_i),
    .rdata_o                 (rdata_o),
    .config_word_two_i       (config_word_two_i),
    .pin_in_i                (pin_in_i),
    .periph_out_i            (periph_out_i),
    .periph_in_o             (periph_in_o),
    .periph_in_valid_o       (periph_in_valid_o),
    .pin_out_o               (pin_out_o),
    .pin_oe_o                (pin_oe_o),
    .remap_lock_o            (remap_lock_o),
    .config_mismatch_reset_o (config_mismatch_reset_o)
  );

  rpsl_far_model model_u (
    .pin_out_i    (pin_out_o),
    .pin_oe_i     (pin_oe_o),
    .pin_in_o     (pin_in_i),
    .periph_out_o (periph_out_i)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic summarize();
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk_i);
    bus_i.we <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge core_clk_i);
    bus_i.re <= 1'b0;
    #1;
    chk({48'h0, rdata_o}, {48'h0, exp});
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  task automatic do_reset(input logic one_way);
    @(posedge core_clk_i);
    rst_i             <= 1'b1;
    config_word_two_i <= {11'h000, one_way, 4'h0};
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask

  // keys and lock change go out back to back, so the strict sequence check sees them
  task automatic unlock(input logic lk);
    @(posedge core_clk_i);
    bus_i <= '{addr: `RPSL_OSC_OFS, wdata: {8'h00, `RPSL_KEY1}, we: 1'b1, re: 1'b0};
    @(posedge core_clk_i);
    bus_i.wdata <= {8'h00, `RPSL_KEY2};
    @(posedge core_clk_i);
    bus_i.wdata <= {9'h000, lk, 6'h00};
    @(posedge core_clk_i);
    bus_i.we <= 1'b0;
  endtask

  task automatic t_reset_values();
    settle();
    rd_chk(`RPSL_IN23_OFS, 16'h3f3f);
    rd_chk(`RPSL_IN27_OFS, 16'h3f3f);
    rd_chk(`RPSL_OSC_OFS, 16'h0000);
    chk({60'h0, periph_in_valid_o}, 64'h0);
    chk({32'h0, pin_oe_o}, 64'h0);
  endtask

  task automatic t_input_route();
    @(posedge core_clk_i);
    model_u.ext_level <= 44'h800_0000_0001;
    wr(`RPSL_IN23_OFS, 16'hebeb);
    settle();
    chk({56'h0, periph_in_o, periph_in_valid_o}, 64'hcc);
    rd_chk(`RPSL_IN23_OFS, 16'h2b2b);
    model_u.ext_level <= 44'h000_0000_0001;
    settle();
    chk({56'h0, periph_in_o, periph_in_valid_o}, 64'h0c);
    wr(`RPSL_IN27_OFS, 16'h2c00);
    settle();
    chk({56'h0, periph_in_o, periph_in_valid_o}, 64'h1d);
    rd_chk(`RPSL_IN27_OFS, 16'h2c00);
    rd_chk(8'h30, 16'h0000);
  endtask

  task automatic t_output_route();
    @(posedge core_clk_i);
    model_u.periph_level <= 64'h0000_0000_0000_0020;
    wr(`RPSL_OUT_BASE, 16'h0505);
    settle();
    chk({pin_out_o, pin_oe_o}, {32'h3, 32'h3});
    wr(8'h20, 16'h0505);
    rd_chk(8'h20, 16'h0000);
    rd_chk(`RPSL_OUT_BASE, 16'h0505);
  endtask

  task automatic t_lock();
    unlock(1'b1);
    settle();
    chk({63'h0, remap_lock_o}, 64'h1);
    rd_chk(`RPSL_OSC_OFS, 16'h0040);
    wr(`RPSL_OUT_BASE, 16'h0000);
    wr(`RPSL_IN23_OFS, 16'h3f3f);
    settle();
    rd_chk(`RPSL_OUT_BASE, 16'h0505);
    rd_chk(`RPSL_IN23_OFS, 16'h2b2b);
    chk({32'h0, pin_oe_o}, 64'h3);
    repeat (50) @(posedge core_clk_i);
    #1;
    chk({63'h0, remap_lock_o}, 64'h1);
    unlock(1'b0);
    settle();
    chk({63'h0, remap_lock_o}, 64'h0);
  endtask

  // a stray write between the keys must cost the whole sequence
  task automatic t_broken_keys();
    wr(`RPSL_OSC_OFS, {8'h00, `RPSL_KEY1});
    wr(8'h20, 16'h0000);
    wr(`RPSL_OSC_OFS, {8'h00, `RPSL_KEY2});
    wr(`RPSL_OSC_OFS, 16'h0040);
    settle();
    chk({63'h0, remap_lock_o}, 64'h0);
    wr(`RPSL_OSC_OFS, {8'h00, `RPSL_KEY1});
    wr(`RPSL_OSC_OFS, {8'h00, `RPSL_KEY2});
    rd_chk(`RPSL_IN23_OFS, 16'h2b2b);
    wr(`RPSL_OSC_OFS, 16'h0040);
    settle();
    chk({63'h0, remap_lock_o}, 64'h1);
    unlock(1'b0);
    settle();
    chk({63'h0, remap_lock_o}, 64'h0);
  endtask

  task automatic t_one_way();
    do_reset(1'b1);
    settle();
    chk({63'h0, remap_lock_o}, 64'h0);
    unlock(1'b1);
    unlock(1'b0);
    settle();
    chk({63'h0, remap_lock_o}, 64'h1);
    wr(`RPSL_IN23_OFS, 16'h0000);
    rd_chk(`RPSL_IN23_OFS, 16'h3f3f);
    do_reset(1'b1);
    settle();
    chk({63'h0, remap_lock_o}, 64'h0);
    chk({63'h0, config_mismatch_reset_o}, 64'h0);
  endtask

  initial
  begin
    rst_i             = 1'b1;
    bus_i             = '0;
    config_word_two_i = 16'h0000;
    bad_count         = 0;
    checks_done       = 0;
    do_reset(1'b0);
    t_reset_values();
    t_input_route();
    t_output_route();
    t_lock();
    t_broken_keys();
    chk({63'h0, config_mismatch_reset_o}, 64'h0);
    t_one_way();
    summarize();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire

// >>> rpsl_far_model.sv
// Purpose: far side of the routing block: external pin levels and peripheral outputs
// Assumes: the bench sets ext_level and periph_level right after a rising edge
// Notes: a pin that the block drives reads back the driven level, as a real pad does
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_params.svh"
module rpsl_far_model (
  input  wire logic [`RPSL_IO_PINS-1:0]     pin_out_i,
  input  wire logic [`RPSL_IO_PINS-1:0]     pin_oe_i,
  output logic      [`RPSL_PINS-1:0]        pin_in_o,
  output logic      [`RPSL_PERIPH_OUTS-1:0] periph_out_o
);
  logic [`RPSL_PINS-1:0]        ext_level;
  logic [`RPSL_PERIPH_OUTS-1:0] periph_level;

  initial
  begin
    ext_level    = '0;
    periph_level = '0;
  end

  // driven pads follow the block, released pads follow the outside world
  assign pin_in_o[`RPSL_IO_PINS-1:0] = (pin_oe_i & pin_out_i) |
                                       (~pin_oe_i & ext_level[`RPSL_IO_PINS-1:0]);
  // input-only pads have no driver inside, 12 pads in all
  assign pin_in_o[`RPSL_PINS-1:`RPSL_IO_PINS] = ext_level[`RPSL_PINS-1:`RPSL_IO_PINS];
  assign periph_out_o = periph_level;
endmodule
`default_nettype wire

// >>> rpsl_params.svh
// Purpose: offsets, field positions, reset values and keys of the pin routing block
// Assumes: register bus carries 8-bit word addresses and 16-bit data
// Notes: included by bare name; definitions only
//
// What this block does
// - one pin may feed many peripheral inputs; one output may drive many pins
// - 44 remappable pins: 32 bidirectional, 12 input only
// - input selector naming no pin, any value above 43, leaves input unconnected
// - output route fields of input-only pins are absent; writes do nothing
// - writes to route registers while locked complete but change nothing
// - remap lock is bit 6 of oscillator control; one blocks route writes
// - remap lock holds until another unlock sequence changes it; never relocks itself
// - shadow copies watch all route registers; difference raises configuration mismatch reset
// - with one-way config bit set, a set lock cannot be cleared
// - under one-way operation only device reset clears the lock
// - one-way bit unprogrammed reads one, one session; zero allows unlimited sessions
// - timer1 clock route bits 13-8, spi2 select route bits 5-0, reset ones
// - uart4 cts route bits 13-8, uart4 receive route bits 5-0, reset ones
`ifndef RPSL_PARAMS_SVH
`define RPSL_PARAMS_SVH
`define RPSL_OSC_OFS     8'h00
`define RPSL_IN23_OFS    8'h01
`define RPSL_IN27_OFS    8'h02
`define RPSL_OUT_BASE    8'h10
`define RPSL_OUT_REGS    8'h16
`define RPSL_OUT_IMPL    8'h10
`define RPSL_LOCK_BIT    6
`define RPSL_ONEWAY_BIT  4
`define RPSL_KEY1        8'h46
`define RPSL_KEY2        8'h57
`define RPSL_SEL_MAX     6'h2b
`define RPSL_PINS        44
`define RPSL_IO_PINS     32
`define RPSL_PERIPH_OUTS 64
`define RPSL_FLD_W       6
`define RPSL_HI_LSB      8
`define RPSL_LO_LSB      0
`define RPSL_SEL_RST     6'h3f
`define RPSL_OUT_RST     6'h00
`define RPSL_LOCK_RST    1'b0
`define RPSL_IN23_LSB    204
`define RPSL_IN27_LSB    192
`define RPSL_ROUTE_BITS  216
`define RPSL_ROUTE_RST   {24'hffffff, 192'h0}
`endif

// >>> rpsl_pkg.sv
// Purpose: shared types of the pin routing block
// Assumes: constants come from rpsl_params.svh
// Notes: nothing here is imported; users write rpsl_pkg::name
`default_nettype none
package rpsl_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } rpsl_bus_req_t;

  typedef struct packed {
    logic timer1_external_clock;
    logic spi2_slave_select_in;
    logic uart4_clear_to_send;
    logic uart4_receive_in;
  } rpsl_periph_in_t;

  typedef enum logic [2:0] {
    RPSL_WAIT_K1 = 3'b001,
    RPSL_WAIT_K2 = 3'b010,
    RPSL_ARMED   = 3'b100
  } rpsl_key_state_t;
endpackage
`default_nettype wire

// >>> rpsl_shadow.sv
// Purpose: shadow copy of every route field with continuous compare
// Assumes: load_i pulses exactly when the live copy takes data_i
// Notes: mismatch is sticky until device reset, which it is meant to cause
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_params.svh"
module rpsl_shadow (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        load_i,
  input  wire logic [`RPSL_ROUTE_BITS-1:0] data_i,
  input  wire logic [`RPSL_ROUTE_BITS-1:0] live_i,
  output logic                             mismatch_o
);
  logic [`RPSL_ROUTE_BITS-1:0] shadow;
  wire                         differs;

  assign differs = (shadow != live_i);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      shadow     <= `RPSL_ROUTE_RST;
      mismatch_o <= 1'b0;
    end
    else
    begin
      if (load_i)
        shadow <= data_i;
      mismatch_o <= mismatch_o | differs;
    end
  end
endmodule
`default_nettype wire

// >>> rpsl_top.sv
// Purpose: remappable pin routing matrix with lock, key sequence and shadow check
// Assumes: bus strobes are one cycle, never together; read data one cycle later
// Notes: unconnected peripheral inputs read low with their valid bit low
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_params.svh"
module rpsl_top (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_i,
  input  wire rpsl_pkg::rpsl_bus_req_t        bus_i,
  output logic [15:0]                         rdata_o,
  input  wire logic [15:0]                    config_word_two_i,
  input  wire logic [`RPSL_PINS-1:0]          pin_in_i,
  input  wire logic [`RPSL_PERIPH_OUTS-1:0]   periph_out_i,
  output rpsl_pkg::rpsl_periph_in_t           periph_in_o,
  output logic [3:0]                          periph_in_valid_o,
  output logic [`RPSL_IO_PINS-1:0]            pin_out_o,
  output logic [`RPSL_IO_PINS-1:0]            pin_oe_o,
  output logic                                remap_lock_o,
  output logic                                config_mismatch_reset_o
);
  logic [`RPSL_ROUTE_BITS-1:0] route_q;
  logic [`RPSL_ROUTE_BITS-1:0] next_route;
  logic                        remap_lock;
  logic                        next_lock;
  logic                        one_way_remap_config;
  wire                         armed;
  wire                         osc_hit;
  wire                         in23_hit;
  wire                         in27_hit;
  wire                         out_hit;
  wire                         out_impl;
  wire [7:0]                   out_off;
  wire [4:0]                   out_idx;
  wire                         wr_ok;
  wire                         in23_wr;
  wire                         in27_wr;
  wire                         out_wr;
  wire                         route_wr;
  wire                         osc_wr;
  wire                         lock_wr;
  wire [15:0]                  rd_mux;
  wire [5:0]                   out_f [0:`RPSL_IO_PINS-1];
  wire [5:0]                   timer1_clock_route;
  wire [5:0]                   spi2_select_route;
  wire [5:0]                   uart4_cts_route;
  wire [5:0]                   uart4_receive_route;

  // a selector above the last pin names nothing
  function automatic logic sel_valid(input logic [5:0] sel);
    sel_valid = (sel <= `RPSL_SEL_MAX);
  endfunction

  function automatic logic sel_pin(input logic [`RPSL_PINS-1:0] pins,
                                   input logic [5:0]            sel);
    sel_pin = sel_valid(sel) ? pins[sel] : 1'b0;
  endfunction

  function automatic logic [15:0] pack_pair(input logic [5:0] hi,
                                            input logic [5:0] lo);
    pack_pair = {2'b00, hi, 2'b00, lo};
  endfunction

  // address decode
  assign osc_hit  = (bus_i.addr == `RPSL_OSC_OFS);
  assign in23_hit = (bus_i.addr == `RPSL_IN23_OFS);
  assign in27_hit = (bus_i.addr == `RPSL_IN27_OFS);
  assign out_off  = bus_i.addr - `RPSL_OUT_BASE;
  assign out_hit  = (bus_i.addr >= `RPSL_OUT_BASE) && (out_off < `RPSL_OUT_REGS);
  assign out_impl = out_hit && (out_off < `RPSL_OUT_IMPL);
  assign out_idx  = out_off[4:0];

  // writes complete either way; only an unlocked write lands
  assign wr_ok    = bus_i.we && !remap_lock;
  assign in23_wr  = wr_ok && in23_hit;
  assign in27_wr  = wr_ok && in27_hit;
  assign out_wr   = wr_ok && out_impl;
  assign route_wr = in23_wr || in27_wr || out_wr;

  // lock change only when armed; one-way mode forbids clearing once set
  assign osc_wr    = bus_i.we && osc_hit;
  assign lock_wr   = osc_wr && armed && !(one_way_remap_config && remap_lock);
  assign next_lock = lock_wr ? bus_i.wdata[`RPSL_LOCK_BIT] : remap_lock;

  rpsl_unlock u_unlock (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .any_wr_i   (bus_i.we),
    .osc_wr_i   (osc_wr),
    .wr_byte_i  (bus_i.wdata[7:0]),
    .armed_o    (armed)
  );

  // next route image: input route pairs, then one field per bidirectional pin
  assign next_route[`RPSL_IN23_LSB +: 12] = in23_wr ?
      {bus_i.wdata[`RPSL_HI_LSB +: 6], bus_i.wdata[`RPSL_LO_LSB +: 6]} :
      route_q[`RPSL_IN23_LSB +: 12];
  assign next_route[`RPSL_IN27_LSB +: 12] = in27_wr ?
      {bus_i.wdata[`RPSL_HI_LSB +: 6], bus_i.wdata[`RPSL_LO_LSB +: 6]} :
      route_q[`RPSL_IN27_LSB +: 12];

  genvar p;
  generate
    for (p = 0; p < `RPSL_IO_PINS; p++)
    begin : g_pin
      localparam logic [4:0] REG_IDX = 5'(p / 2);
      localparam int         FLD_LSB = (p % 2 == 1) ? `RPSL_HI_LSB : `RPSL_LO_LSB;
      assign next_route[p*6 +: 6] = (out_wr && (out_idx == REG_IDX)) ?
                                    bus_i.wdata[FLD_LSB +: 6] : route_q[p*6 +: 6];
      assign out_f[p] = route_q[p*6 +: 6];

      // each pin picks independently, so one output may drive many pins
      always_ff @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          pin_out_o[p] <= 1'b0;
          pin_oe_o[p]  <= 1'b0;
        end
        else
        begin
          pin_out_o[p] <= periph_out_i[out_f[p]];
          pin_oe_o[p]  <= (out_f[p] != `RPSL_OUT_RST);
        end
      end
    end
  endgenerate

  assign timer1_clock_route  = route_q[`RPSL_IN23_LSB + 6 +: 6];
  assign spi2_select_route   = route_q[`RPSL_IN23_LSB +: 6];
  assign uart4_cts_route     = route_q[`RPSL_IN27_LSB + 6 +: 6];
  assign uart4_receive_route = route_q[`RPSL_IN27_LSB +: 6];

  // read-back; reserved bits and unmapped or input-only slots read zero
  assign rd_mux = osc_hit  ? {9'h000, remap_lock, 6'h00} :
                  in23_hit ? pack_pair(timer1_clock_route, spi2_select_route) :
                  in27_hit ? pack_pair(uart4_cts_route, uart4_receive_route) :
                  out_impl ? pack_pair(out_f[{out_idx[3:0], 1'b1}],
                                       out_f[{out_idx[3:0], 1'b0}]) :
                             16'h0000;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else
      rdata_o <= bus_i.re ? rd_mux : 16'h0000;
  end

  // one-way bit is caught while reset is held; unprogrammed reads one
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      one_way_remap_config <= config_word_two_i[`RPSL_ONEWAY_BIT];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      route_q    <= `RPSL_ROUTE_RST;
      remap_lock <= `RPSL_LOCK_RST;
    end
    else
    begin
      route_q    <= next_route;
      remap_lock <= next_lock;
    end
  end

  assign remap_lock_o = remap_lock;

  // peripheral inputs may all share one pin
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      periph_in_o       <= '0;
      periph_in_valid_o <= 4'h0;
    end
    else
    begin
      periph_in_o.timer1_external_clock <= sel_pin(pin_in_i, timer1_clock_route);
      periph_in_o.spi2_slave_select_in  <= sel_pin(pin_in_i, spi2_select_route);
      periph_in_o.uart4_clear_to_send   <= sel_pin(pin_in_i, uart4_cts_route);
      periph_in_o.uart4_receive_in      <= sel_pin(pin_in_i, uart4_receive_route);
      periph_in_valid_o <= {sel_valid(timer1_clock_route), sel_valid(spi2_select_route),
                            sel_valid(uart4_cts_route), sel_valid(uart4_receive_route)};
    end
  end

  // shadow loads only on accepted writes, so any other change shows up
  rpsl_shadow u_shadow (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_i     (route_wr),
    .data_i     (next_route),
    .live_i     (route_q),
    .mismatch_o (config_mismatch_reset_o)
  );

  property p_locked_write_ignored;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.we && remap_lock && (in23_hit || in27_hit || out_hit)) |=> $stable(route_q);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored)
    else $error("route changed by a locked write");

  property p_key_sequence;
    @(posedge core_clk_i) disable iff (rst_i)
      (osc_wr && bus_i.wdata[7:0] == `RPSL_KEY1) ##1
      (osc_wr && bus_i.wdata[7:0] == `RPSL_KEY2) ##1
      (osc_wr && !(one_way_remap_config && remap_lock))
      |=> (remap_lock == $past(bus_i.wdata[`RPSL_LOCK_BIT]));
  endproperty
  a_key_sequence: assert property (p_key_sequence)
    else $error("lock not changed after both keys");

  property p_no_stray_lock_change;
    @(posedge core_clk_i) disable iff (rst_i)
      !(osc_wr && armed) |=> $stable(remap_lock);
  endproperty
  a_no_stray_lock_change: assert property (p_no_stray_lock_change)
    else $error("lock changed without an armed write");

  property p_one_way_sticky;
    @(posedge core_clk_i) disable iff (rst_i)
      (one_way_remap_config && remap_lock) |=> remap_lock;
  endproperty
  a_one_way_sticky: assert property (p_one_way_sticky)
    else $error("one-way lock was cleared");

  property p_invalid_sel;
    @(posedge core_clk_i) disable iff (rst_i)
      (spi2_select_route > `RPSL_SEL_MAX)
      |=> (!periph_in_valid_o[2] && !periph_in_o.spi2_slave_select_in);
  endproperty
  a_invalid_sel: assert property (p_invalid_sel)
    else $error("invalid selector left an input connected");

  property p_input_only_slot;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.re && out_hit && !out_impl) |=> (rdata_o == 16'h0000);
  endproperty
  a_input_only_slot: assert property (p_input_only_slot)
    else $error("input-only pin slot read nonzero");

  property p_unlocked_write_lands;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.we && in27_hit && !remap_lock) |=>
      (uart4_cts_route == $past(bus_i.wdata[13:8]) &&
       uart4_receive_route == $past(bus_i.wdata[5:0]));
  endproperty
  a_unlocked_write_lands: assert property (p_unlocked_write_lands)
    else $error("unlocked route write lost");

  property p_reset_values;
    @(posedge core_clk_i)
      $fell(rst_i) |-> (route_q[`RPSL_IN23_LSB +: 12] == 12'hfff && !remap_lock);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong route reset value");

  property p_fan_out;
    @(posedge core_clk_i) disable iff (rst_i)
      (out_f[0] == out_f[1]) |=> (pin_out_o[0] == pin_out_o[1]);
  endproperty
  a_fan_out: assert property (p_fan_out)
    else $error("shared output differs between pins");

  property p_shadow_quiet;
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(config_mismatch_reset_o) |-> !$past(route_wr);
  endproperty
  a_shadow_quiet: assert property (p_shadow_quiet)
    else $error("mismatch raised by a legal write");

  property p_lock_readback;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.re && osc_hit) |=> (rdata_o == {9'h000, $past(remap_lock), 6'h00});
  endproperty
  a_lock_readback: assert property (p_lock_readback)
    else $error("lock bit read back wrong");

  property p_reserved_zero;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.re && (in23_hit || in27_hit)) |=> ((rdata_o & 16'hc0c0) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved input route bits read nonzero");

  property p_input_only_write;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.we && out_hit && !out_impl) |=> $stable(route_q);
  endproperty
  a_input_only_write: assert property (p_input_only_write)
    else $error("input-only pin slot write changed a route");

  property p_oe_follows_route;
    @(posedge core_clk_i) disable iff (rst_i)
      (out_f[0] != `RPSL_OUT_RST) |=> pin_oe_o[0];
  endproperty
  a_oe_follows_route: assert property (p_oe_follows_route)
    else $error("routed pin not driven");

  property p_shared_input;
    @(posedge core_clk_i) disable iff (rst_i)
      (timer1_clock_route == uart4_receive_route) |=>
      (periph_in_o.timer1_external_clock == periph_in_o.uart4_receive_in);
  endproperty
  a_shared_input: assert property (p_shared_input)
    else $error("shared input pin seen differently");

  property p_valid_sel;
    @(posedge core_clk_i) disable iff (rst_i)
      (uart4_receive_route <= `RPSL_SEL_MAX) |=> periph_in_valid_o[0];
  endproperty
  a_valid_sel: assert property (p_valid_sel)
    else $error("valid selector left input unconnected");

  property p_out_write_lands;
    @(posedge core_clk_i) disable iff (rst_i)
      (bus_i.we && !remap_lock && out_impl && (out_idx == 5'h00)) |=>
      (out_f[1] == $past(bus_i.wdata[13:8]) && out_f[0] == $past(bus_i.wdata[5:0]));
  endproperty
  a_out_write_lands: assert property (p_out_write_lands)
    else $error("unlocked output route write lost");

  property p_many_sessions;
    @(posedge core_clk_i) disable iff (rst_i)
      (!one_way_remap_config && armed && osc_wr) |=>
      (remap_lock == $past(bus_i.wdata[`RPSL_LOCK_BIT]));
  endproperty
  a_many_sessions: assert property (p_many_sessions)
    else $error("armed lock change refused without one-way mode");

  property p_armed_consumed;
    @(posedge core_clk_i) disable iff (rst_i)
      (armed && bus_i.we) |=> !armed;
  endproperty
  a_armed_consumed: assert property (p_armed_consumed)
    else $error("armed state survived a write");

  c_unlock_session: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(remap_lock));
  c_locked_write: cover property (@(posedge core_clk_i) disable iff (rst_i)
    bus_i.we && remap_lock && in23_hit);
  c_one_way_block: cover property (@(posedge core_clk_i) disable iff (rst_i)
    osc_wr && armed && one_way_remap_config && remap_lock);
  c_invalid_sel: cover property (@(posedge core_clk_i) disable iff (rst_i)
    periph_in_valid_o == 4'h0);
endmodule
`default_nettype wire

// >>> rpsl_unlock.sv
// Purpose: two-key detector that arms a single lock change
// Assumes: any_wr_i pulses on every bus write, osc_wr_i on writes to oscillator control
// Notes: the armed state is consumed by the very next write, whatever it hits
`timescale 1ns/1ps
`default_nettype none
`include "rpsl_params.svh"
module rpsl_unlock (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       any_wr_i,
  input  wire logic       osc_wr_i,
  input  wire logic [7:0] wr_byte_i,
  output logic            armed_o
);
  rpsl_pkg::rpsl_key_state_t state;
  rpsl_pkg::rpsl_key_state_t next_state;
  wire is_key1;
  wire is_key2;

  assign is_key1 = osc_wr_i && (wr_byte_i == `RPSL_KEY1);
  assign is_key2 = osc_wr_i && (wr_byte_i == `RPSL_KEY2);
  assign armed_o = (state == rpsl_pkg::RPSL_ARMED);

  // any write out of order other than a repeated first key drops back to waiting for the first key
  always_comb
  begin
    next_state = state;
    if (any_wr_i)
    begin
      case (state)
        rpsl_pkg::RPSL_WAIT_K1: next_state = is_key1 ? rpsl_pkg::RPSL_WAIT_K2
                                                     : rpsl_pkg::RPSL_WAIT_K1;
        rpsl_pkg::RPSL_WAIT_K2: next_state = is_key2 ? rpsl_pkg::RPSL_ARMED :
                                             is_key1 ? rpsl_pkg::RPSL_WAIT_K2 :
                                                       rpsl_pkg::RPSL_WAIT_K1;
        rpsl_pkg::RPSL_ARMED:   next_state = rpsl_pkg::RPSL_WAIT_K1;
        default:                next_state = rpsl_pkg::RPSL_WAIT_K1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      state <= rpsl_pkg::RPSL_WAIT_K1;
    else
      state <= next_state;
  end
endmodule
`default_nettype wire
